/* File: src/emp_defs.svh */
`ifndef EMP_DEFS_SVH
`define EMP_DEFS_SVH
// Functional notes
// - stop or wait releases mastership; all port pins go high impedance.
// - address lines driven only while bus master, else high impedance.
// - address holds last value when no external access is running.
// - data lines bidirectional as master, otherwise drivers off.
// - stop/wait keeps data direction; inputs ignored; data ignored during reset.
// - attribute lines act as chip selects or extra address lines.
// - by default at most one attribute line asserted at a time.
// - priority-off bit 14 makes attribute lines a 4-bit encoded field.
// - alternate function makes attribute lines row strobes, programmable polarity.
// - active-low read strobe as master, else high impedance.
// - active-low write strobe as master, else high impedance.
// - cycle ends one clock after ack sampled, at least programmed waits.

// ----------------------------------------
// widths and fields
// ----------------------------------------
`define EMP_ADDR_W        18
`define EMP_DATA_W        24
`define EMP_ATTR_W        4
`define EMP_WAIT_W        5
`define EMP_OMR_APD_BIT   14
`define EMP_ADDR_RST      18'h00000
`define EMP_DATA_RST      24'h000000
`define EMP_WAIT_RST      5'h00
`define EMP_ATTR_OFF      4'h0
`endif

/* File: src/emp_pkg.sv */
package emp_pkg;
  typedef enum logic [3:0] {
    EMP_IDLE = 4'h1,
    EMP_WAIT = 4'h2,
    EMP_ACK  = 4'h4,
    EMP_DONE = 4'h8
  } emp_state_t;
endpackage

/* File: src/emp_attr_prio.sv */
`timescale 1ns/1ps
`include "emp_defs.svh"
module emp_attr_prio (
  input  wire logic [`EMP_ATTR_W-1:0] req,
  input  wire logic                   prio_off,
  output logic      [`EMP_ATTR_W-1:0] sel
);
  logic [`EMP_ATTR_W-1:0] lower_hit;
  // ----------------------------------------
  // lowest index wins
  // ----------------------------------------
  assign lower_hit[0] = 1'b0;
  genvar i;
  generate
    for (i = 1; i < `EMP_ATTR_W; i++) begin : g_pri
      assign lower_hit[i] = lower_hit[i-1] | req[i-1];
    end
  endgenerate
  assign sel = prio_off ? req : (req & ~lower_hit);
endmodule

/* File: src/emp_port.sv */
`timescale 1ns/1ps
`include "emp_defs.svh"
module emp_port (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   bus_grant,
  input  wire logic                   standby,
  input  wire logic                   attr_priority_off,
  input  wire logic                   ras_mode,
  input  wire logic [`EMP_ATTR_W-1:0] ras_active_high,
  input  wire logic [`EMP_WAIT_W-1:0] min_waits,
  input  wire logic                   dram_access,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic [`EMP_ADDR_W-1:0] req_addr,
  input  wire logic [`EMP_DATA_W-1:0] req_wdata,
  input  wire logic [`EMP_ATTR_W-1:0] req_attr,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic      [`EMP_DATA_W-1:0] rsp_rdata,
  output logic                        is_master,
  output logic      [`EMP_ADDR_W-1:0] addr_o,
  output logic                        addr_oe,
  input  wire logic [`EMP_DATA_W-1:0] data_i,
  output logic      [`EMP_DATA_W-1:0] data_o,
  output logic                        data_oe,
  output logic      [`EMP_ATTR_W-1:0] attr_select_o,
  output logic                        attr_select_oe,
  output logic                        rd_n_o,
  output logic                        wr_n_o,
  output logic                        strobe_oe,
  output logic                        bus_busy_n_o,
  output logic                        bus_busy_n_oe,
  input  wire logic                   transfer_ack_n
);
  typedef struct packed {
    emp_pkg::emp_state_t    st;
    logic                   master;
    logic                   wr;
    logic                   dram;
    logic [`EMP_ADDR_W-1:0] addr;
    logic [`EMP_DATA_W-1:0] wdata;
    logic [`EMP_ATTR_W-1:0] attr;
    logic [`EMP_WAIT_W-1:0] cnt;
    logic                   dir_out;
    logic                   rvalid;
    logic [`EMP_DATA_W-1:0] rdata;
  } emp_regs_t;

  emp_regs_t              s_reg;
  emp_regs_t              s_next;
  logic [`EMP_ATTR_W-1:0] attr_sel;
  logic                   active;
  logic                   ack_seen;

  emp_attr_prio u_prio (
    .req      (req_attr),
    .prio_off (attr_priority_off),
    .sel      (attr_sel)
  );

  // dram or zero-wait cycles never honour the ack input
  assign ack_seen = !transfer_ack_n && (min_waits != `EMP_WAIT_RST) && !s_reg.dram;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next        = s_reg;
    s_next.rvalid = 1'b0;
    s_next.master = bus_grant && !standby;
    unique case (s_reg.st)
      emp_pkg::EMP_IDLE: begin
        if (req_valid && s_next.master && s_reg.master) begin
          s_next.st      = emp_pkg::EMP_WAIT;
          s_next.wr      = req_write;
          s_next.dram    = dram_access;
          s_next.addr    = req_addr;
          s_next.wdata   = req_wdata;
          s_next.attr    = attr_sel;
          s_next.cnt     = min_waits;
          s_next.dir_out = req_write;
        end
      end
      emp_pkg::EMP_WAIT: begin
        if (s_reg.cnt != `EMP_WAIT_RST) begin
          s_next.cnt = s_reg.cnt - 5'h01;
        end
        // cycle ends one clock after ack once minimum waits are spent
        if (s_reg.cnt == `EMP_WAIT_RST) begin
          if (ack_seen || min_waits == `EMP_WAIT_RST || s_reg.dram) begin
            s_next.st = emp_pkg::EMP_ACK;
          end
        end
      end
      emp_pkg::EMP_ACK: begin
        s_next.st = emp_pkg::EMP_DONE;
        if (!s_reg.wr && !standby) begin
          s_next.rdata  = data_i;
          s_next.rvalid = 1'b1;
        end
      end
      emp_pkg::EMP_DONE: begin
        s_next.st   = emp_pkg::EMP_IDLE;
        s_next.attr = `EMP_ATTR_OFF;
      end
    endcase
    if (!s_next.master) begin
      s_next.st   = emp_pkg::EMP_IDLE;
      s_next.attr = `EMP_ATTR_OFF;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{st: emp_pkg::EMP_IDLE, master: 1'b0, wr: 1'b0, dram: 1'b0,
                 addr: `EMP_ADDR_RST, wdata: `EMP_DATA_RST, attr: `EMP_ATTR_OFF,
                 cnt: `EMP_WAIT_RST, dir_out: 1'b0, rvalid: 1'b0,
                 rdata: `EMP_DATA_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign active         = s_reg.st != emp_pkg::EMP_IDLE;
  assign req_ready      = s_reg.st == emp_pkg::EMP_IDLE && s_reg.master && !standby;
  assign rsp_valid      = s_reg.rvalid;
  assign rsp_rdata      = s_reg.rdata;
  assign is_master      = s_reg.master;
  assign addr_o         = s_reg.addr;
  assign addr_oe        = s_reg.master;
  assign data_o         = s_reg.wdata;
  assign data_oe        = s_reg.master && s_reg.dir_out && active;
  // row strobe polarity per line; attribute lines are active low otherwise
  assign attr_select_o  = ras_mode ? ~(s_reg.attr ^ ras_active_high) : ~s_reg.attr;
  assign attr_select_oe = s_reg.master;
  assign rd_n_o         = !(active && !s_reg.wr);
  assign wr_n_o         = !(active && s_reg.wr && s_reg.st != emp_pkg::EMP_DONE);
  assign strobe_oe      = s_reg.master;
  assign bus_busy_n_o   = !s_reg.master;
  assign bus_busy_n_oe  = s_reg.master;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  release_on_standby_a: assert property (@(posedge clk) disable iff (!reset_n)
    standby |=> !addr_oe && !data_oe && !strobe_oe && !attr_select_oe)
    else $error("pins driven in standby");
  addr_float_a: assert property (@(posedge clk) disable iff (!reset_n)
    !is_master |-> !addr_oe)
    else $error("address driven without mastership");
  addr_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!active && !(req_valid && req_ready)) |=> $stable(addr_o))
    else $error("address toggled while idle");
  data_dir_a: assert property (@(posedge clk) disable iff (!reset_n)
    data_oe |-> is_master && rd_n_o)
    else $error("data driven during read or as slave");
  read_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
    rsp_valid |-> $past(s_reg.st == emp_pkg::EMP_ACK) && !$past(s_reg.wr))
    else $error("read data taken outside read cycle");
  attr_onehot_a: assert property (@(posedge clk) disable iff (!reset_n)
    !attr_priority_off |-> $onehot0(attr_sel))
    else $error("more than one attribute line");
  attr_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    attr_priority_off |-> attr_sel == req_attr)
    else $error("encoded attribute altered");
  strobe_excl_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(!rd_n_o && !wr_n_o))
    else $error("read and write strobes together");
  write_float_a: assert property (@(posedge clk) disable iff (!reset_n)
    !is_master |-> !strobe_oe)
    else $error("write strobe driven as slave");
  ack_end_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_reg.st == emp_pkg::EMP_WAIT && s_reg.cnt == `EMP_WAIT_RST && ack_seen
     && s_next.master) |=> s_reg.st == emp_pkg::EMP_ACK)
    else $error("cycle not ended after ack");
  min_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s_reg.st == emp_pkg::EMP_WAIT && s_reg.cnt != `EMP_WAIT_RST) |=> s_reg.st != emp_pkg::EMP_ACK)
    else $error("minimum waits cut short");

  read_cov: cover property (@(posedge clk) disable iff (!reset_n) rsp_valid);
  write_cov: cover property (@(posedge clk) disable iff (!reset_n) !wr_n_o);
  stretch_cov: cover property (@(posedge clk) disable iff (!reset_n)
    s_reg.st == emp_pkg::EMP_WAIT ##1 s_reg.st == emp_pkg::EMP_WAIT [*3]);
  standby_cov: cover property (@(posedge clk) disable iff (!reset_n) active ##1 standby);
endmodule

/* File: testbench/emp_mem_model.sv */
`timescale 1ns/1ps
module emp_mem_model (
  input  wire logic        clk,
  input  wire logic [17:0] addr_o,
  input  wire logic        rd_n_o,
  input  wire logic        wr_n_o,
  input  wire logic        strobe_oe,
  input  wire logic [23:0] data_o,
  input  wire logic        data_oe,
  input  wire logic [4:0]  ack_waits,
  output logic      [23:0] data_i,
  output logic             transfer_ack_n
);
  logic [23:0] mem [16];
  logic [23:0] last_reg = 24'h000000;
  logic [4:0]  cnt_reg  = 5'h00;
  wire         active   = strobe_oe && !(rd_n_o && wr_n_o);
  // released bus flips every cycle so a stale copy never passes
  assign data_i = (active && !rd_n_o) ? mem[addr_o[3:0]] : ~last_reg;
  // ack only held off when the bench asks for stretching
  assign transfer_ack_n = !(active && cnt_reg >= ack_waits);
  always_ff @(posedge clk) begin
    if (active && !wr_n_o && data_oe) begin
      mem[addr_o[3:0]] <= data_o;
    end
    last_reg <= data_i;
    cnt_reg  <= active ? cnt_reg + 5'h01 : 5'h00;
  end
endmodule

/* File: testbench/external_memory_port_signals_tb.sv */
`timescale 1ns/1ps
module external_memory_port_signals_tb;
  logic        clk, reset_n, bus_grant, standby, attr_priority_off, ras_mode, dram_access;
  logic        req_valid, req_write, req_ready, rsp_valid, is_master, addr_oe, data_oe;
  logic        attr_select_oe, rd_n_o, wr_n_o, strobe_oe, transfer_ack_n;
  logic        bus_busy_n_o, bus_busy_n_oe;
  logic [3:0]  ras_active_high, req_attr, attr_select_o, got_attr;
  logic [4:0]  min_waits, ack_waits;
  logic [17:0] req_addr, addr_o, got_addr;
  logic [23:0] req_wdata, rsp_rdata, data_i, data_o, got_d;
  int          n_mismatch = 0, compares = 0, lat;
  emp_port emp_port_inst (.clk, .reset_n, .bus_grant, .standby, .attr_priority_off, .ras_mode,
    .ras_active_high, .min_waits, .dram_access, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_attr, .req_ready, .rsp_valid, .rsp_rdata, .is_master, .addr_o, .addr_oe, .data_i,
    .data_o, .data_oe, .attr_select_o, .attr_select_oe, .rd_n_o, .wr_n_o, .strobe_oe,
    .bus_busy_n_o, .bus_busy_n_oe, .transfer_ack_n);
  emp_mem_model emp_mem_model_inst (.clk, .addr_o, .rd_n_o, .wr_n_o, .strobe_oe, .data_o,
    .data_oe, .ack_waits, .data_i, .transfer_ack_n);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (exp !== got) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // lat counts cycles after the take; bus pins captured while a strobe is low
  task automatic xfer(input logic wr, input logic [17:0] a, input logic [23:0] d);
    int i;
    i = 0;
    while (req_ready !== 1'h1 && i < 50) begin
      @(posedge clk);
      #1;
      i++;
    end
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    req_valid = 1'h1;
    @(posedge clk);
    #1;
    req_valid = 1'h0;
    lat = 1;
    while (lat < 60 && (wr ? req_ready : rsp_valid) !== 1'h1) begin
      if (rd_n_o === 1'h0 || wr_n_o === 1'h0) begin
        got_attr = attr_select_o;
        got_addr = addr_o;
      end
      @(posedge clk);
      #1;
      lat++;
    end
    got_d = rsp_rdata;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("oe idle", 32'h0, {addr_oe, data_oe, attr_select_oe, strobe_oe, is_master});
    bus_grant = 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("master", 32'h1, is_master);
    chk("busy", 32'h2, {bus_busy_n_oe, bus_busy_n_o});
  endtask
  task automatic t_write_read();
    xfer(1'h1, 18'h00005, 24'hA5C3F0);
    chk("wr addr", 32'h5, got_addr);
    xfer(1'h1, 18'h0000A, 24'h5A3C0F);
    xfer(1'h0, 18'h00005, 24'h000000);
    chk("rd data", 32'hA5C3F0, got_d);
  endtask
  task automatic t_latency();
    min_waits = 5'h04;
    xfer(1'h0, 18'h0000A, 24'h000000);
    chk("lat min", 32'h7, lat);
    min_waits = 5'h01;
    ack_waits = 5'h08;
    xfer(1'h0, 18'h0000A, 24'h000000);
    chk("lat ack", 32'hB, lat);
    min_waits = 5'h00;
    xfer(1'h0, 18'h0000A, 24'h000000);
    chk("lat zero", 32'h3, lat);
    min_waits = 5'h01;
    ack_waits = 5'h00;
    repeat (5) @(posedge clk);
    #1;
    chk("addr hold", 32'hA, addr_o);
  endtask
  task automatic t_attr();
    xfer(1'h0, 18'h00005, 24'h000000);
    chk("attr prio", 32'hE, got_attr);
    attr_priority_off = 1'h1;
    xfer(1'h0, 18'h00005, 24'h000000);
    chk("attr field", 32'h0, got_attr);
    ras_mode        = 1'h1;
    ras_active_high = 4'h5;
    xfer(1'h0, 18'h00005, 24'h000000);
    chk("ras level", 32'h5, got_attr);
    @(posedge clk);
    #1;
    chk("ras idle", 32'hA, attr_select_o);
    ras_mode        = 1'h0;
  endtask
  task automatic t_standby();
    standby = 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("oe stby", 32'h0, {addr_oe, data_oe, attr_select_oe, strobe_oe, is_master});
    chk("ready stby", 32'h0, req_ready);
    chk("busy stby", 32'h1, {bus_busy_n_oe, bus_busy_n_o});
  endtask
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    #50000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {reset_n, bus_grant, standby, attr_priority_off, ras_mode, dram_access} = 6'h00;
    {req_valid, req_write, req_addr, req_wdata} = 44'h0;
    ras_active_high = 4'h0;
    req_attr        = 4'hF;
    min_waits       = 5'h01;
    ack_waits       = 5'h00;
    repeat (12) @(posedge clk);
    #1 reset_n = 1'h1;
    t_reset();
    t_write_read();
    t_latency();
    t_attr();
    t_standby();
    final_report();
  end
endmodule
